/* testbench/cdmr_regs_properties.sv */
// Port-level assertions for the display mode register block
`timescale 1ns/1ps
module cdmr_regs_checker #(
	parameter int PANEL_WIDTH = 4,
	parameter int LINE_CYCLES = 20,
	parameter int FRAME_LINES = 30
) (
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic [9:0]             ioAddr,
	input wire logic                   aen,
	input wire logic                   ioRead_n,
	input wire logic                   ioWrite_n,
	input wire logic [7:0]             ioWrData,
	input wire logic [7:0]             ioRdData,
	input wire logic                   ioRdEnable,
	input wire logic [PANEL_WIDTH-1:0] upperHalfData,
	input wire logic [PANEL_WIDTH-1:0] lowerHalfData,
	input wire logic [PANEL_WIDTH-1:0] upper_panel_data,
	input wire logic                   video_on_hint,
	input wire logic                   attrBlinkMode,
	input wire logic                   underlineOn,
	input wire logic                   grayscaleOn,
	input wire logic                   display_page_select,
	input wire logic                   singleTextPage,
	input wire logic                   tall_panel_select,
	input wire logic [2:0]             displayMode
);
	// ********************************************************************
	// Access decode, kept apart from the design's own decode
	// ********************************************************************
	wire portHit;  // Any of the mapped ports
	wire wrA;      // Accepted write to mode A
	wire wrB;      // Accepted write to mode B
	wire rdA;      // Read of mode A
	wire rdS;      // Read of status
	assign portHit = (ioAddr[9:3] == 7'h7a) || (ioAddr == 10'h3d8)
		|| (ioAddr == 10'h3da) || (ioAddr == 10'h3de);
	assign wrA = !aen && !ioWrite_n && (ioAddr == 10'h3d8);
	assign wrB = !aen && !ioWrite_n && (ioAddr == 10'h3de);
	assign rdA = !aen && !ioRead_n && (ioAddr == 10'h3d8);
	assign rdS = !aen && !ioRead_n && (ioAddr == 10'h3da);

	// One domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ********************************************************************
	// Assertions
	// ********************************************************************
	a_read_enable: assert property (ioRdEnable == (!aen && !ioRead_n && portHit))
		else $error("read enable does not follow decode");
	a_blocked_write: assert property (aen |=> $stable(video_on_hint) && $stable(underlineOn))
		else $error("register changed while address enable high");
	a_gray_inverse: assert property (grayscaleOn == !underlineOn)
		else $error("grayscale not inverse of underline");
	a_mode_a_fields: assert property (wrA |=> video_on_hint == $past(ioWrData[3])
		&& attrBlinkMode == $past(ioWrData[5]))
		else $error("mode A outputs wrong after write");
	a_mode_b_fields: assert property (wrB |=> underlineOn == $past(ioWrData[6])
		&& display_page_select == $past(ioWrData[3])
		&& singleTextPage == $past(ioWrData[0]))
		else $error("mode B outputs wrong after write");
	a_text_decode: assert property (wrA && !ioWrData[1] |=>
		displayMode == {2'h0, $past(ioWrData[0])})
		else $error("text mode decode wrong");
	a_low_res_gfx: assert property (wrA && ioWrData[1] && !ioWrData[4] |=> displayMode == 3'h2)
		else $error("low resolution graphics decode wrong");
	a_status_fixed: assert property (rdS |=> ioRdData[7:4] == 4'hf && ioRdData[2:1] == 2'h2)
		else $error("status fixed bits wrong");
	a_reserved_zero: assert property (rdA |=> (ioRdData & 8'hc4) == 8'h00)
		else $error("mode A reserved bits not zero");
	a_ink_bypass: assert property (!$past(rst) && !$past(tall_panel_select) |->
		upper_panel_data == $past(upperHalfData))
		else $error("panel data altered outside tall mode");
endmodule : cdmr_regs_checker

/* testbench/cdmr_tb.sv */
// Self-checking bench for the display mode register block
`timescale 1ns/1ps
module tb;
	// ********************************************************************
	// Stimulus signals and counters
	// ********************************************************************
	logic       clk_sys;            // 200 MHz system clock
	logic       rst;                // Async reset
	logic [9:0] ioAddr;             // Address A0-A9
	logic       aen;                // Address enable
	logic       ioRead_n;           // Read strobe
	logic       ioWrite_n;          // Write strobe
	logic [7:0] ioWrData;           // Write data
	logic [7:0] ioRdData;           // Read data
	logic       ioRdEnable;         // Bus drive
	logic [3:0] upperHalfData;      // Upper screen nibble
	logic [3:0] lowerHalfData;      // Lower screen nibble
	logic [3:0] upper_panel_data;   // Merged nibble
	logic       video_on_hint;
	logic       attrBlinkMode;
	logic       underlineOn;
	logic       grayscaleOn;
	logic       display_page_select;
	logic       singleTextPage;
	logic       tall_panel_select;
	logic [2:0] displayMode;
	int         errTotal;           // Mismatches
	int         checkCount;         // Comparisons
	int         cycles;             // Timeout count

	// Short line and frame keep a full frame to a few hundred clocks
	cdmr_regs #(.PANEL_WIDTH(4), .LINE_CYCLES(20), .FRAME_LINES(30)) dut (
		.clk_sys(clk_sys), .rst(rst), .ioAddr(ioAddr), .aen(aen),
		.ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdEnable(ioRdEnable),
		.upperHalfData(upperHalfData), .lowerHalfData(lowerHalfData),
		.upper_panel_data(upper_panel_data), .video_on_hint(video_on_hint),
		.attrBlinkMode(attrBlinkMode), .underlineOn(underlineOn),
		.grayscaleOn(grayscaleOn), .display_page_select(display_page_select),
		.singleTextPage(singleTextPage),
		.tall_panel_select(tall_panel_select), .displayMode(displayMode));

	// ********************************************************************
	// Tasks: compare, bus cycles, verdict
	// ********************************************************************
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checkCount++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			errTotal++;
		end
	endtask : chk

	// One-cycle write strobe; outputs settled on return
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		ioAddr   <= a;
		ioWrData <= d;
		ioWrite_n <= 1'b0;
		@(posedge clk_sys);
		ioWrite_n <= 1'b1;
		#1;
	endtask : wr

	// Enable seen in the strobe cycle, data after the next edge
	task automatic rd(input logic [9:0] a, output logic [7:0] d,
		output logic en);
		@(posedge clk_sys);
		ioAddr   <= a;
		ioRead_n <= 1'b0;
		#1 en = ioRdEnable;
		@(posedge clk_sys);
		ioRead_n <= 1'b1;
		#1 d = ioRdData;
	endtask : rd

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// ********************************************************************
	// Clock, timeout and test sequence
	// ********************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Whole sequence needs about 920 clocks
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errTotal++;
			complete_run();
		end
	end

	initial
	begin
		logic [7:0] d;
		logic       e;
		logic [1:0] hSeen;
		logic [1:0] vSeen;
		logic [7:0] tA [5] = '{8'h00, 8'h01, 8'h02, 8'h12, 8'h12};
		logic [7:0] tB [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		logic [3:0] inkExp [4] = '{4'hc, 4'he, 4'hc, 4'ha};
		{errTotal, checkCount, cycles} = '0;
		{rst, aen, ioRead_n, ioWrite_n} = 4'hb;
		{ioAddr, ioWrData, hSeen, vSeen} = '0;
		upperHalfData = 4'ha;
		lowerHalfData = 4'h6;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		rd(10'h3d8, d, e); chk("modeA reset", d, 8'h00);
		rd(10'h3de, d, e); chk("modeB reset", d, 8'h00);
		// Reserved bits drop, fields reach outputs
		wr(10'h3d8, 8'hff); rd(10'h3d8, d, e); chk("modeA", d, 8'h3b);
		chk("video hint", {7'h0, video_on_hint}, 8'h01);
		chk("blink", {7'h0, attrBlinkMode}, 8'h01);
		wr(10'h3de, 8'hff); rd(10'h3de, d, e); chk("modeB", d, 8'h49);
		chk("gray", {7'h0, grayscaleOn}, 8'h00);
		chk("page", {7'h0, display_page_select}, 8'h01);
		chk("one page", {7'h0, singleTextPage}, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			wr(10'h3d8, tA[i]);
			wr(10'h3de, tB[i]);
			chk("mode", {5'h0, displayMode}, i[7:0]);
		end
		// Address enable high and unmapped ports are ignored
		@(posedge clk_sys) aen <= 1'b1;
		wr(10'h3d8, 8'h00); rd(10'h3d8, d, e); chk("aen en", {7'h0, e}, 8'h00);
		@(posedge clk_sys) aen <= 1'b0;
		rd(10'h3d8, d, e); chk("aen write", d, 8'h12);
		rd(10'h3d9, d, e); chk("unmapped", {7'h0, e}, 8'h00);
		// Absent timing index reads zero
		wr(10'h3d4, 8'h05); wr(10'h3d5, 8'h55); rd(10'h3d5, d, e); chk("crt idx", d, 8'h00);
		// Tall panel on, each ink code through a different alias pair
		wr(10'h3d4, 8'hcc); wr(10'h3d5, 8'h04);
		chk("tall", {7'h0, tall_panel_select}, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			wr(10'h3d0 + {7'h0, i[1:0], 1'b0}, 8'hcd);
			wr(10'h3d1 + {7'h0, i[1:0], 1'b0}, 8'h80 | i[7:0]);
			rd(10'h3d4, d, e); chk("index", d, 8'hcd);
			rd(10'h3d5, d, e); chk("ink reg", d, 8'h80 | i[7:0]);
			repeat (2) @(posedge clk_sys);
			#1 chk("ink merge", {4'h0, upper_panel_data}, {4'h0, inkExp[i]});
		end
		wr(10'h3d5, 8'h7e); rd(10'h3d5, d, e); chk("ink rsvd", d, 8'h02);
		repeat (2) @(posedge clk_sys);
		#1 chk("ink off", {4'h0, upper_panel_data}, 8'h0a);
		// Poll status across more than a frame
		repeat (400)
		begin
			rd(10'h3da, d, e);
			chk("status", d & 8'hf6, 8'hf4);
			hSeen[d[0]] = 1'b1;
			vSeen[d[3]] = 1'b1;
		end
		chk("line flag", {6'h0, hSeen}, 8'h03);
		chk("frame flag", {6'h0, vSeen}, 8'h03);
		complete_run();
	end
endmodule : tb

bind cdmr_regs cdmr_regs_checker #(.PANEL_WIDTH(PANEL_WIDTH),
	.LINE_CYCLES(LINE_CYCLES), .FRAME_LINES(FRAME_LINES)) chkInst (
	.clk_sys(clk_sys), .rst(rst), .ioAddr(ioAddr), .aen(aen),
	.ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .ioWrData(ioWrData),
	.ioRdData(ioRdData), .ioRdEnable(ioRdEnable),
	.upperHalfData(upperHalfData), .lowerHalfData(lowerHalfData),
	.upper_panel_data(upper_panel_data), .video_on_hint(video_on_hint),
	.attrBlinkMode(attrBlinkMode), .underlineOn(underlineOn),
	.grayscaleOn(grayscaleOn), .display_page_select(display_page_select),
	.singleTextPage(singleTextPage), .tall_panel_select(tall_panel_select),
	.displayMode(displayMode));

/* verilog/cdmr_ink_merge.sv */
// Ink plane merge of lower-half data onto upper-half panel data
`timescale 1ns/1ps
module cdmr_ink_merge #(
	parameter int WIDTH = 4
) (
	input  wire logic [WIDTH-1:0] upperData,   // Upper half screen nibble
	input  wire logic [WIDTH-1:0] lowerData,   // Lower half screen nibble
	input  wire logic             inkActive,   // Enable and tall mode
	input  wire logic [1:0]       combineSel,  // Combine method
	output      logic [WIDTH-1:0] mergedData   // Drives upper panel data
);

	// ********************************************************************
	// Combine methods
	// ********************************************************************
	// Modulate inverts the upper pixel where ink is present
	wire [WIDTH-1:0] modData = upperData ^ lowerData;
	wire [WIDTH-1:0] orData  = upperData | lowerData;
	wire [WIDTH-1:0] xorData = upperData ^ lowerData;
	// Modulate here: upper pixel inverted wherever lower pixel is lit, same as XOR
	wire [WIDTH-1:0] modOut  = modData & ~lowerData | lowerData & ~upperData;

	// Reserved code passes upper data untouched
	wire [WIDTH-1:0] selData =
		(combineSel == cdmr_pkg::CDMR_INK_MODULATE) ? modOut  :
		(combineSel == cdmr_pkg::CDMR_INK_OR)       ? orData  :
		(combineSel == cdmr_pkg::CDMR_INK_XOR)      ? xorData :
		upperData;

	assign mergedData = inkActive ? selData : upperData;

endmodule : cdmr_ink_merge

/* verilog/cdmr_pkg.sv */
// Package: offsets, field positions, reset values and timing for the block
package cdmr_pkg;

	// ********************************************************************
	// I/O port map (ten-bit decode)
	// ********************************************************************
	localparam logic [9:0] PORT_INDEX_MAIN   = 10'h3d4; // Index primary
	localparam logic [9:0] PORT_DATA_MAIN    = 10'h3d5; // Data primary
	localparam logic [9:0] PORT_PAIR_BASE    = 10'h3d0; // Alias group base
	localparam logic [9:0] PORT_MODE_PRIMARY = 10'h3d8; // Mode A
	localparam logic [9:0] PORT_STATUS       = 10'h3da; // Retrace status
	localparam logic [9:0] PORT_MODE_SECOND  = 10'h3de; // Mode B

	// ********************************************************************
	// Index space
	// ********************************************************************
	localparam logic [7:0] IDX_CRT_FIRST     = 8'h01;   // First absent index
	localparam logic [7:0] IDX_CRT_LAST      = 8'h09;   // Last absent index
	localparam logic [7:0] IDX_TALL_PANEL    = 8'hcc;   // Panel mode index
	localparam logic [7:0] IDX_INK           = 8'hcd;   // Ink overlay index

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int BIT_INK_EN      = 7;
	localparam int BIT_TALL_PANEL  = 2;
	localparam int BIT_BLINK       = 5;
	localparam int BIT_GRES_LO     = 4;
	localparam int BIT_VIDEO       = 3;
	localparam int BIT_GRAPH       = 1;
	localparam int BIT_COLUMNS     = 0;
	localparam int BIT_UNDERLINE   = 6;
	localparam int BIT_PAGE        = 3;
	localparam int BIT_GRES_HI     = 0;
	localparam int BIT_VRETRACE    = 3;
	localparam int BIT_HRETRACE    = 0;

	// Writable masks; every other bit is reserved, reads zero
	localparam logic [7:0] MASK_INK        = 8'h83;
	localparam logic [7:0] MASK_TALL       = 8'h04;
	localparam logic [7:0] MASK_MODE_A     = 8'h3b;
	localparam logic [7:0] MASK_MODE_B     = 8'h49;
	localparam logic [7:0] STATUS_FIXED    = 8'hf4; // Bits 7..4 and 2 high

	// Values after reset
	localparam logic [7:0] RESET_REG       = 8'h00;
	localparam logic [7:0] RESET_INDEX     = 8'h00;

	// ********************************************************************
	// Retrace simulation timing
	// ********************************************************************
	localparam int LINE_CYCLES       = 12800; // Clocks per simulated line
	localparam int LINE_RETRACE      = 1600;  // Clocks of line retrace
	localparam int FRAME_LINES       = 262;   // Lines per simulated frame
	localparam int FRAME_RETRACE     = 22;    // Lines of frame retrace

	// Ink combine methods
	typedef enum logic [1:0] {
		CDMR_INK_MODULATE = 2'h0,
		CDMR_INK_OR       = 2'h1,
		CDMR_INK_XOR      = 2'h2,
		CDMR_INK_RSVD     = 2'h3
	} cdmr_ink_t;

	// Decoded display mode
	typedef enum logic [2:0] {
		CDMR_TEXT_40,
		CDMR_TEXT_80,
		CDMR_GFX_320,
		CDMR_GFX_640,
		CDMR_GFX_640_TALL
	} cdmr_mode_t;

endpackage : cdmr_pkg

/* verilog/cdmr_regs.sv */
// Compatibility display mode registers with ink overlay and retrace status
// ********************************************************************
// Overview of operation
// - Ink enabled in tall mode merges halves
// - Two-bit field picks modulate, OR, XOR
// - Index port 3D4, data port 3D5
// - Aliases at 3D0/1, 3D2/3, 3D6/7 behave identically
// - Decode A0-A9 only, accept with AEN low
// - CRT timing indices one to nine absent
// - Blink bit: attribute top bit blinks or intensifies
// - Video bit only feeds power management
// - Mode decoded from graphics, columns, resolution bits
// - Status: retrace bits, bit2 and 7..4 ones
// - Underline bit enables underline, stops grayscale
// - Page bit selects low or high page
// - High-res bit: tall graphics, one 32K page
// - Separate tall panel control gates ink
// ********************************************************************
`timescale 1ns/1ps
module cdmr_regs #(
	parameter int PANEL_WIDTH   = 4,
	parameter int LINE_CYCLES   = cdmr_pkg::LINE_CYCLES,
	parameter int FRAME_LINES   = cdmr_pkg::FRAME_LINES
) (
	input  wire logic                   clk_sys,        // System clock
	input  wire logic                   rst,            // Async reset
	input  wire logic [9:0]             ioAddr,         // Address A0-A9
	input  wire logic                   aen,            // Address enable
	input  wire logic                   ioRead_n,       // I/O read strobe
	input  wire logic                   ioWrite_n,      // I/O write strobe
	input  wire logic [7:0]             ioWrData,       // Write data
	output      logic [7:0]             ioRdData,       // Read data
	output      logic                   ioRdEnable,     // Drive data bus
	input  wire logic [PANEL_WIDTH-1:0] upperHalfData,  // Upper screen
	input  wire logic [PANEL_WIDTH-1:0] lowerHalfData,  // Lower screen
	output      logic [PANEL_WIDTH-1:0] upper_panel_data, // To panel
	output      logic                   video_on_hint,  // To power mgmt
	output      logic                   attrBlinkMode,  // Top bit blinks
	output      logic                   underlineOn,    // Underline active
	output      logic                   grayscaleOn,    // Grayscale active
	output      logic                   display_page_select, // High page
	output      logic                   singleTextPage, // One 32K page
	output      logic                   tall_panel_select, // 400 lines
	output      logic [2:0]             displayMode     // Decoded mode
);

	// ********************************************************************
	// Registers
	// ********************************************************************
	logic [7:0] compat_index_select;     // Index register
	logic [7:0] display_mode_primary;    // Mode A
	logic [7:0] display_mode_secondary;  // Mode B
	logic [7:0] ink_overlay_control;     // Ink register
	logic [7:0] panelModeReg;            // Tall panel control
	logic [PANEL_WIDTH-1:0] panelOut;    // Registered panel data
	logic [7:0] readLatch;               // Registered read data
	logic       hRetrace;                // Line retrace flag
	logic       vRetrace;                // Frame retrace flag

	// ********************************************************************
	// Address decode
	// ********************************************************************
	// Only ten lines are compared, so upper aliases also hit
	wire        ioSelect   = ~aen;
	// A0 to A2 are dropped so all eight ports fold onto the base
	wire [9:0]  pairBase   = ioAddr & 10'h3f8;
	wire        inPair     = ioSelect && (pairBase == cdmr_pkg::PORT_PAIR_BASE);
	// Within the pair group, even ports index and odd ports data
	wire        hitIndex   = inPair && !ioAddr[0];
	wire        hitData    = inPair &&  ioAddr[0];
	wire        hitModeA   = ioSelect &&
		(ioAddr == cdmr_pkg::PORT_MODE_PRIMARY);
	wire        hitStatus  = ioSelect && (ioAddr == cdmr_pkg::PORT_STATUS);
	wire        hitModeB   = ioSelect &&
		(ioAddr == cdmr_pkg::PORT_MODE_SECOND);
	wire        anyHit     = hitIndex | hitData | hitModeA |
		hitStatus | hitModeB;

	wire        wrStrobe   = ~ioWrite_n;
	wire        rdStrobe   = ~ioRead_n;

	// Indexed targets; CRT timing indices have nothing behind them
	wire        idxInk     = (compat_index_select == cdmr_pkg::IDX_INK);
	wire        idxTall    = (compat_index_select ==
		cdmr_pkg::IDX_TALL_PANEL);
	wire        idxCrt     = (compat_index_select >= cdmr_pkg::IDX_CRT_FIRST)
		&& (compat_index_select <= cdmr_pkg::IDX_CRT_LAST);

	wire        wrIndex    = wrStrobe && hitIndex;
	wire        wrInk      = wrStrobe && hitData && idxInk && !idxCrt;
	wire        wrTall     = wrStrobe && hitData && idxTall && !idxCrt;
	wire        wrModeA    = wrStrobe && hitModeA;
	wire        wrModeB    = wrStrobe && hitModeB;

	// ********************************************************************
	// Read multiplexer
	// ********************************************************************
	wire [7:0] statusValue = cdmr_pkg::STATUS_FIXED |
		{4'h0, vRetrace, 2'b00, hRetrace};

	// Unimplemented indices read zero
	wire [7:0] dataValue =
		idxInk  ? ink_overlay_control :
		idxTall ? panelModeReg :
		8'h00;

	wire [7:0] next_readLatch =
		hitIndex  ? compat_index_select :
		hitData   ? dataValue :
		hitModeA  ? display_mode_primary :
		hitModeB  ? display_mode_secondary :
		hitStatus ? statusValue :
		8'h00;

	assign ioRdEnable = rdStrobe && anyHit;

	// ********************************************************************
	// Register writes
	// ********************************************************************
	// Index register holds whatever software last wrote
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			compat_index_select <= cdmr_pkg::RESET_INDEX;
		else if (wrIndex)
			compat_index_select <= ioWrData;
	end

	// Mode A: reserved bits masked so they stay zero
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			display_mode_primary <= cdmr_pkg::RESET_REG;
		else if (wrModeA)
			display_mode_primary <= ioWrData & cdmr_pkg::MASK_MODE_A;
	end

	// Mode B: reserved bits masked
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			display_mode_secondary <= cdmr_pkg::RESET_REG;
		else if (wrModeB)
			display_mode_secondary <= ioWrData & cdmr_pkg::MASK_MODE_B;
	end

	// Ink register through the index/data pair
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ink_overlay_control <= cdmr_pkg::RESET_REG;
		else if (wrInk)
			ink_overlay_control <= ioWrData & cdmr_pkg::MASK_INK;
	end

	// Tall panel control, only bit 2 kept
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			panelModeReg <= cdmr_pkg::RESET_REG;
		else if (wrTall)
			panelModeReg <= ioWrData & cdmr_pkg::MASK_TALL;
	end

	// Read data registered so the bus sees a stable byte
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			readLatch <= 8'h00;
		else if (rdStrobe)
			readLatch <= next_readLatch;
	end

	// Data phase uses the latch once the strobe has been seen
	assign ioRdData = readLatch;

	// ********************************************************************
	// Mode outputs
	// ********************************************************************
	wire graphMode   = display_mode_primary[cdmr_pkg::BIT_GRAPH];
	wire columnSel   = display_mode_primary[cdmr_pkg::BIT_COLUMNS];
	wire gresLo      = display_mode_primary[cdmr_pkg::BIT_GRES_LO];
	wire gresHi      = display_mode_secondary[cdmr_pkg::BIT_GRES_HI];

	// Resolution 10 is not a listed mode; treated as 320 graphics
	wire [2:0] next_displayMode =
		!graphMode ? (columnSel ? 3'(cdmr_pkg::CDMR_TEXT_80) :
			3'(cdmr_pkg::CDMR_TEXT_40)) :
		!gresLo    ? 3'(cdmr_pkg::CDMR_GFX_320) :
		gresHi     ? 3'(cdmr_pkg::CDMR_GFX_640_TALL) :
		3'(cdmr_pkg::CDMR_GFX_640);

	// Video bit goes to power management only, not to the panel path
	assign video_on_hint = display_mode_primary[cdmr_pkg::BIT_VIDEO];
	assign attrBlinkMode = display_mode_primary[cdmr_pkg::BIT_BLINK];
	assign underlineOn   = display_mode_secondary[cdmr_pkg::BIT_UNDERLINE];
	assign grayscaleOn   = ~display_mode_secondary[cdmr_pkg::BIT_UNDERLINE];
	assign display_page_select =
		display_mode_secondary[cdmr_pkg::BIT_PAGE];
	assign singleTextPage = gresHi;
	assign tall_panel_select = panelModeReg[cdmr_pkg::BIT_TALL_PANEL];
	assign displayMode   = next_displayMode;

	// ********************************************************************
	// Ink overlay path
	// ********************************************************************
	wire inkEnable = ink_overlay_control[cdmr_pkg::BIT_INK_EN];
	wire inkActive = inkEnable && tall_panel_select;
	wire [PANEL_WIDTH-1:0] mergedData;

	cdmr_ink_merge #(
		.WIDTH      (PANEL_WIDTH)
	) u_ink (
		.upperData  (upperHalfData),
		.lowerData  (lowerHalfData),
		.inkActive  (inkActive),
		.combineSel (ink_overlay_control[1:0]),
		.mergedData (mergedData)
	);

	// Panel data registered; one cycle of latency from screen inputs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			panelOut <= '0;
		else
			panelOut <= mergedData;
	end

	assign upper_panel_data = panelOut;

	// ********************************************************************
	// Retrace simulation
	// ********************************************************************
	// Retrace spans scale with the period, so a line of at least 8 clocks and a frame
	// of at least 12 lines keep both flag states; default periods give the package spans
	localparam int LINE_RETRACE_SCALED =
		LINE_CYCLES * cdmr_pkg::LINE_RETRACE / cdmr_pkg::LINE_CYCLES;
	localparam int FRAME_RETRACE_SCALED =
		FRAME_LINES * cdmr_pkg::FRAME_RETRACE / cdmr_pkg::FRAME_LINES;

	cdmr_retrace_gen #(
		.LINE_CYCLES   (LINE_CYCLES),
		.LINE_RETRACE  (LINE_RETRACE_SCALED),
		.FRAME_LINES   (FRAME_LINES),
		.FRAME_RETRACE (FRAME_RETRACE_SCALED)
	) u_retrace (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.hRetrace (hRetrace),
		.vRetrace (vRetrace)
	);

endmodule : cdmr_regs

/* verilog/cdmr_retrace_gen.sv */
// Simulated line and frame retrace flag generator
`timescale 1ns/1ps
module cdmr_retrace_gen #(
	parameter int LINE_CYCLES   = cdmr_pkg::LINE_CYCLES,
	parameter int LINE_RETRACE  = cdmr_pkg::LINE_RETRACE,
	parameter int FRAME_LINES   = cdmr_pkg::FRAME_LINES,
	parameter int FRAME_RETRACE = cdmr_pkg::FRAME_RETRACE
) (
	input  wire logic clk_sys,      // System clock
	input  wire logic rst,          // Asynchronous reset
	output      logic hRetrace,     // Simulated line retrace
	output      logic vRetrace      // Simulated frame retrace
);

	// ********************************************************************
	// Counters
	// ********************************************************************
	logic [15:0] lineCount;         // Clock position in line
	logic [9:0]  frameCount;        // Line position in frame

	wire lineEnd  = (lineCount == 16'(LINE_CYCLES - 1));
	wire frameEnd = (frameCount == 10'(FRAME_LINES - 1));

	// Line counter wraps every line period
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			lineCount <= 16'h0000;
		else
			lineCount <= lineEnd ? 16'h0000 : lineCount + 16'h0001;
	end

	// Frame counter steps once per line, an enable pulse
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			frameCount <= 10'h000;
		else if (lineEnd)
			frameCount <= frameEnd ? 10'h000 : frameCount + 10'h001;
	end

	// Flags registered; both states seen by a polling loop
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			hRetrace <= 1'b0;
			vRetrace <= 1'b0;
		end
		else
		begin
			hRetrace <= (lineCount >= 16'(LINE_CYCLES - LINE_RETRACE));
			vRetrace <= (frameCount >= 10'(FRAME_LINES - FRAME_RETRACE));
		end
	end

endmodule : cdmr_retrace_gen
